// >>> pkg/ddcb_pkg.sv
/*
  Constants for the converter configuration block: register indices,
  reset values, field positions and hold timing.
  Assumes a 32-bit APB bus; each register sits at byte address 4 * index.
*/
package ddcb_pkg;
  // register indices (byte address is four times the index)
  localparam logic [9:0] IDX_THRESH_I = 10'h211;
  localparam logic [9:0] IDX_THRESH_Q = 10'h212;
  localparam logic [9:0] IDX_OVER_RANGE_OUTPUT_CONFIG = 10'h213;
  localparam logic [9:0] IDX_MODE = 10'h214;
  localparam logic [9:0] IDX_SEL = 10'h215;
  localparam logic [9:0] IDX_BIND = 10'h216;
  localparam logic [9:0] IDX_FREQ_A = 10'h220;
  localparam logic [9:0] IDX_FREQ_B = 10'h224;
  localparam logic [9:0] IDX_PHASE_A = 10'h228;
  localparam logic [9:0] IDX_PHASE_B = 10'h22C;
  localparam logic [9:0] IDX_CTRL = 10'h230;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h231;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h232;
  // reset values
  localparam logic [7:0] RST_THRESH_I = 8'hF2;
  localparam logic [7:0] RST_THRESH_Q = 8'hAB;
  localparam logic [7:0] RST_OVER_RANGE_OUTPUT_CONFIG = 8'h07;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] RST_BIND = 8'h02;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [31:0] RST_FREQ = 32'hC0000000;
  localparam logic [15:0] RST_PHASE = 16'h0000;
  // field positions
  localparam int OVER_RANGE_PIN_ENABLE_BIT = 3;
  localparam int BIND_A_BIT = 0;
  localparam int BIND_B_BIT = 1;
  localparam int CTRL_PD_A = 0;
  localparam int CTRL_PD_B = 1;
  localparam int CTRL_SINGLE = 2;
  localparam int CTRL_LINK_EN = 3;
  localparam int CTRL_CAL_EN = 4;
  // hold timing: base pulse of 8 device clock cycles, shifted by the exponent
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] HOLD_BASE = 11'h008;
  typedef enum logic [1:0] {MODE_REG, MODE_PINS_AB, MODE_PINS_A, MODE_RSVD} ddcb_mode_t;
endpackage

// >>> verilog/ddcb_top.sv
/*
  Over-range pin stretching, NCO preset selection and digital channel
  binding for a dual-channel converter, with an APB register slave.
  Assumes all inputs synchronous to pclk except the preset pins, which
  are resynchronised here; samples arrive one per clock.
*/
// Register access over APB was chosen for this implementation.
// Notes on behaviour
// - Enable bit clear holds all four over-range pins low.
// - Enable gates only the pins; link over-range bits stay ungated.
// - An asserted over-range pin stays high at least 8 * 2^exponent cycles.
// - Each exponent step doubles the hold; exponent resets to 7.
// - Mode 0 takes both presets from the select register; mode 3 reserved.
// - Mode 1 takes preset A from pins A, preset B from pins B.
// - Mode 2 takes both presets from pins A; pins B ignored.
// - Four frequency and phase presets per converter; selected one drives NCO.
// - Single-channel operation uses channel A's selection method.
// - Mode 0: select bits 3:2 choose preset B; ignored single-channel.
// - Mode 0: select bits 1:0 value n activates preset n for A.
// - Single-channel, mode 0: select A field chooses the single NCO preset.
// - Binding bit 1: digital B from converter A (0) or B (1).
// - Binding bit 0: digital A from converter A (0) or B (1).
// - Digital channel powers down with the converter channel it is bound to.
// - I samples versus threshold one set bit 0; Q versus threshold two bit 1.
module ddcb_top
  import ddcb_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // preset select pins
  input wire logic [1:0] preset_pins_a,
  input wire logic [1:0] preset_pins_b,
  // down-converter output samples
  input wire logic signed [15:0] ddc_i_a,
  input wire logic signed [15:0] ddc_q_a,
  input wire logic signed [15:0] ddc_i_b,
  input wire logic signed [15:0] ddc_q_b,
  // converter channel data
  input wire logic [15:0] conv_data_a,
  input wire logic [15:0] conv_data_b,
  // over-range outputs
  output logic chan_a_range_flag_zero,
  output logic chan_a_range_flag_one,
  output logic chan_b_range_flag_zero,
  output logic chan_b_range_flag_one,
  output logic [3:0] link_range_bits,
  // active nco settings
  output logic [1:0] active_preset_a,
  output logic [1:0] active_preset_b,
  output logic [31:0] active_freq_a,
  output logic [31:0] active_freq_b,
  output logic [15:0] active_phase_a,
  output logic [15:0] active_phase_b,
  // digital channels
  output logic [15:0] dig_data_a,
  output logic [15:0] dig_data_b,
  output logic dig_pd_a,
  output logic dig_pd_b,
  output logic serial_link_enable,
  output logic cal_enable,
  output logic single_channel,
  // interrupt
  output logic irq
);
  import ddcb_pkg::*;

  logic [7:0] thresh_i;
  logic [7:0] thresh_q;
  logic [7:0] over_range_output_config;
  logic [7:0] mode_reg;
  logic [7:0] sel_reg;
  logic [7:0] bind_reg;
  logic [7:0] ctrl_reg;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [31:0] freq_a [4];
  logic [31:0] freq_b [4];
  logic [15:0] phase_a [4];
  logic [15:0] phase_b [4];
  logic [9:0] idx;
  logic wr_en;
  logic [31:0] next_rdata;
  logic next_err;
  logic [3:0] hit;
  logic [3:0] active;
  logic [CNT_W-1:0] hold_len;
  logic [3:0] next_stat;
  logic [1:0] pa_meta;
  logic [1:0] pa_sync;
  logic [1:0] pb_meta;
  logic [1:0] pb_sync;
  logic [1:0] next_sel_a;
  logic [1:0] next_sel_b;

  assign idx = paddr[11:2];
  assign wr_en = psel & penable & pready & pwrite;

  // read mux and decode, evaluated in the setup cycle
  always_comb
  begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (idx[9:2] == IDX_FREQ_A[9:2])
      next_rdata = freq_a[idx[1:0]];
    else if (idx[9:2] == IDX_FREQ_B[9:2])
      next_rdata = freq_b[idx[1:0]];
    else if (idx[9:2] == IDX_PHASE_A[9:2])
      next_rdata = {16'h0000, phase_a[idx[1:0]]};
    else if (idx[9:2] == IDX_PHASE_B[9:2])
      next_rdata = {16'h0000, phase_b[idx[1:0]]};
    else
    begin
      case (idx)
        IDX_THRESH_I: next_rdata = {24'h000000, thresh_i};
        IDX_THRESH_Q: next_rdata = {24'h000000, thresh_q};
        IDX_OVER_RANGE_OUTPUT_CONFIG: next_rdata = {24'h000000, over_range_output_config};
        IDX_MODE: next_rdata = {24'h000000, mode_reg};
        IDX_SEL: next_rdata = {24'h000000, sel_reg};
        IDX_BIND: next_rdata = {24'h000000, bind_reg};
        IDX_CTRL: next_rdata = {24'h000000, ctrl_reg};
        IDX_IRQ_STAT: next_rdata = {28'h0000000, irq_stat};
        IDX_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
        default: next_err = 1'b1;
      endcase
    end
  end

  // one access cycle: ready and data registered from the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      prdata <= (psel & ~penable & ~pwrite) ? next_rdata : 32'h00000000;
      pslverr <= psel & ~penable & next_err;
    end
  end

  // byte-wide configuration registers and the 4-bit interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      thresh_i <= RST_THRESH_I;
      thresh_q <= RST_THRESH_Q;
      over_range_output_config <= RST_OVER_RANGE_OUTPUT_CONFIG;
      mode_reg <= RST_MODE;
      sel_reg <= RST_SEL;
      bind_reg <= RST_BIND;
      ctrl_reg <= RST_CTRL;
      irq_mask <= 4'h0;
    end
    else if (wr_en)
    begin
      case (idx)
        IDX_THRESH_I: thresh_i <= pwdata[7:0];
        IDX_THRESH_Q: thresh_q <= pwdata[7:0];
        IDX_OVER_RANGE_OUTPUT_CONFIG: over_range_output_config <= pwdata[7:0];
        IDX_MODE: mode_reg <= pwdata[7:0];
        IDX_SEL: sel_reg <= pwdata[7:0];
        IDX_BIND: bind_reg <= pwdata[7:0];
        IDX_CTRL: ctrl_reg <= pwdata[7:0];
        IDX_IRQ_MASK: irq_mask <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // preset storage, four entries per converter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int k = 0; k < 4; k++)
      begin
        freq_a[k] <= RST_FREQ;
        freq_b[k] <= RST_FREQ;
        phase_a[k] <= RST_PHASE;
        phase_b[k] <= RST_PHASE;
      end
    end
    else if (wr_en)
    begin
      if (idx[9:2] == IDX_FREQ_A[9:2])
        freq_a[idx[1:0]] <= pwdata;
      if (idx[9:2] == IDX_FREQ_B[9:2])
        freq_b[idx[1:0]] <= pwdata;
      if (idx[9:2] == IDX_PHASE_A[9:2])
        phase_a[idx[1:0]] <= pwdata[15:0];
      if (idx[9:2] == IDX_PHASE_B[9:2])
        phase_b[idx[1:0]] <= pwdata[15:0];
    end
  end

  // magnitude against a threshold scaled to 256 = full scale
  function automatic logic over_level(input logic signed [15:0] s, input logic [7:0] t);
    logic [15:0] m;
    m = s[15] ? 16'(-s) : 16'(s);
    return m[15:7] >= {1'b0, t};
  endfunction

  assign hit[0] = over_level(ddc_i_a, thresh_i);
  assign hit[1] = over_level(ddc_q_a, thresh_q);
  assign hit[2] = over_level(ddc_i_b, thresh_i);
  assign hit[3] = over_level(ddc_q_b, thresh_q);
  assign hold_len = HOLD_BASE << over_range_output_config[2:0];

  // per-flag stretch counters
  for (genvar g = 0; g < 4; g++)
  begin : g_hold
    logic [CNT_W-1:0] cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cnt <= '0;
      else if (hit[g])
        cnt <= hold_len - 11'h001;
      else if (cnt != '0)
        cnt <= cnt - 11'h001;
    end
    assign active[g] = hit[g] | (cnt != '0);
  end

  // pins gated by the enable; link bits are not
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_a_range_flag_zero <= 1'b0;
      chan_a_range_flag_one <= 1'b0;
      chan_b_range_flag_zero <= 1'b0;
      chan_b_range_flag_one <= 1'b0;
      link_range_bits <= 4'h0;
    end
    else
    begin
      chan_a_range_flag_zero <= over_range_output_config[OVER_RANGE_PIN_ENABLE_BIT] & active[0];
      chan_a_range_flag_one <= over_range_output_config[OVER_RANGE_PIN_ENABLE_BIT] & active[1];
      chan_b_range_flag_zero <= over_range_output_config[OVER_RANGE_PIN_ENABLE_BIT] & active[2];
      chan_b_range_flag_one <= over_range_output_config[OVER_RANGE_PIN_ENABLE_BIT] & active[3];
      link_range_bits <= hit;
    end
  end

  // sticky status, a new hit beats a clearing write
  assign next_stat = (irq_stat & ~((wr_en && idx == IDX_IRQ_STAT) ? pwdata[3:0] : 4'h0)) | hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat <= next_stat;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // two-flop synchronisers on the select pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_meta <= 2'h0;
      pa_sync <= 2'h0;
      pb_meta <= 2'h0;
      pb_sync <= 2'h0;
    end
    else
    begin
      pa_meta <= preset_pins_a;
      pa_sync <= pa_meta;
      pb_meta <= preset_pins_b;
      pb_sync <= pb_meta;
    end
  end

  // preset source; reserved mode behaves as register mode
  always_comb
  begin
    case (ddcb_mode_t'(mode_reg[1:0]))
      MODE_PINS_AB:
      begin
        next_sel_a = pa_sync;
        next_sel_b = pb_sync;
      end
      MODE_PINS_A:
      begin
        next_sel_a = pa_sync;
        next_sel_b = pa_sync;
      end
      default:
      begin
        next_sel_a = sel_reg[1:0];
        next_sel_b = sel_reg[3:2];
      end
    endcase
    if (ctrl_reg[CTRL_SINGLE])
      next_sel_b = next_sel_a;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_preset_a <= 2'h0;
      active_preset_b <= 2'h0;
      active_freq_a <= RST_FREQ;
      active_freq_b <= RST_FREQ;
      active_phase_a <= RST_PHASE;
      active_phase_b <= RST_PHASE;
    end
    else
    begin
      active_preset_a <= next_sel_a;
      active_preset_b <= next_sel_b;
      active_freq_a <= freq_a[next_sel_a];
      active_freq_b <= freq_b[next_sel_b];
      active_phase_a <= phase_a[next_sel_a];
      active_phase_b <= phase_b[next_sel_b];
    end
  end

  // channel binding and inherited power-down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dig_data_a <= 16'h0000;
      dig_data_b <= 16'h0000;
      dig_pd_a <= 1'b0;
      dig_pd_b <= 1'b0;
      serial_link_enable <= 1'b0;
      cal_enable <= 1'b0;
      single_channel <= 1'b0;
    end
    else
    begin
      dig_data_a <= bind_reg[BIND_A_BIT] ? conv_data_b : conv_data_a;
      dig_data_b <= bind_reg[BIND_B_BIT] ? conv_data_b : conv_data_a;
      dig_pd_a <= bind_reg[BIND_A_BIT] ? ctrl_reg[CTRL_PD_B] : ctrl_reg[CTRL_PD_A];
      dig_pd_b <= bind_reg[BIND_B_BIT] ? ctrl_reg[CTRL_PD_B] : ctrl_reg[CTRL_PD_A];
      serial_link_enable <= ctrl_reg[CTRL_LINK_EN];
      cal_enable <= ctrl_reg[CTRL_CAL_EN];
      single_channel <= ctrl_reg[CTRL_SINGLE];
    end
  end

  property p_pins_off;
    @(posedge pclk) disable iff (!presetn)
    !over_range_output_config[OVER_RANGE_PIN_ENABLE_BIT] |=> !chan_a_range_flag_zero && !chan_a_range_flag_one
      && !chan_b_range_flag_zero && !chan_b_range_flag_one;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("range pin high while disabled");

  property p_link_raw;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> link_range_bits == $past(hit);
  endproperty
  a_link_raw: assert property (p_link_raw) else $error("link range bits gated");

  property p_min_pulse;
    @(posedge pclk) disable iff (!presetn)
    $rose(chan_a_range_flag_zero) && over_range_output_config == $past(over_range_output_config) |-> chan_a_range_flag_zero[*8];
  endproperty
  a_min_pulse: assert property (p_min_pulse) else $error("range pulse too short");

  property p_hold_load;
    @(posedge pclk) disable iff (!presetn)
    hit[0] |=> g_hold[0].cnt == $past((HOLD_BASE << over_range_output_config[2:0]) - 11'h001);
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("hold count wrong");

  property p_reg_mode;
    @(posedge pclk) disable iff (!presetn)
    mode_reg[1:0] == 2'h0 && !ctrl_reg[CTRL_SINGLE]
      |=> active_preset_a == $past(sel_reg[1:0]) && active_preset_b == $past(sel_reg[3:2]);
  endproperty
  a_reg_mode: assert property (p_reg_mode) else $error("register preset not applied");

  property p_pin_mode;
    @(posedge pclk) disable iff (!presetn)
    mode_reg[1:0] == 2'h1 && !ctrl_reg[CTRL_SINGLE]
      |=> active_preset_a == $past(pa_sync) && active_preset_b == $past(pb_sync);
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("pin presets not applied");

  property p_pin_a_mode;
    @(posedge pclk) disable iff (!presetn)
    mode_reg[1:0] == 2'h2 |=> active_preset_b == $past(pa_sync);
  endproperty
  a_pin_a_mode: assert property (p_pin_a_mode) else $error("pins A not shared");

  property p_freq_pick;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> active_freq_a == $past(freq_a[next_sel_a]);
  endproperty
  a_freq_pick: assert property (p_freq_pick) else $error("wrong active frequency");

  property p_single;
    @(posedge pclk) disable iff (!presetn)
    ctrl_reg[CTRL_SINGLE] |=> active_preset_b == active_preset_a;
  endproperty
  a_single: assert property (p_single) else $error("single channel select mismatch");

  property p_pd_bind;
    @(posedge pclk) disable iff (!presetn)
    bind_reg[BIND_B_BIT] == 1'b0 |=> dig_pd_b == $past(ctrl_reg[CTRL_PD_A]);
  endproperty
  a_pd_bind: assert property (p_pd_bind) else $error("power-down not inherited");
endmodule

// >>> tb/ddcb_ctrl_model.sv
/*
  External controller model: drives the preset select pins and measures
  the width of the last over-range pulse it saw.
  Assumes requests from the bench arrive synchronous to pclk.
*/
module ddcb_ctrl_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requested presets and watched flag
  input wire logic [1:0] want_a,
  input wire logic [1:0] want_b,
  input wire logic range_flag,
  // pins and measured width
  output logic [1:0] preset_pins_a,
  output logic [1:0] preset_pins_b,
  output logic [11:0] pulse_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] run;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      preset_pins_a <= 2'h0;
      preset_pins_b <= 2'h0;
    end
    else
    begin
      preset_pins_a <= want_a;
      preset_pins_b <= want_b;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run <= 12'h000;
      pulse_len <= 12'h000;
    end
    else if (range_flag)
      run <= run + 12'h001;
    else if (run != 12'h000)
    begin
      pulse_len <= run;
      run <= 12'h000;
    end
  end
endmodule

// >>> tb/tb_top.sv
/*
  Self-checking bench for ddcb_top: APB tasks, binding, power-down,
  preset selection, over-range stretching and interrupt sequences.
  Assumes ddcb_pkg and the controller model ddcb_ctrl_model.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ddcb_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, fr_a, fr_b, rdv;
  logic pready, pslverr, irq, errv, pd_a, pd_b;
  logic link_en, cal_en, single;
  logic [1:0] want_a = 2'h0;
  logic [1:0] want_b = 2'h0;
  logic [1:0] pins_a, pins_b, pre_a, pre_b;
  logic [15:0] smp = 16'h0000;
  logic [15:0] conv_a = 16'h1A1A;
  logic [15:0] conv_b = 16'h2B2B;
  logic [15:0] dig_a, dig_b, ph_a, ph_b;
  logic [3:0] flags, link;
  logic [11:0] plen;
  int num_errors = 0;
  int n_tests = 0;
  always #25 pclk = ~pclk;
  ddcb_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .preset_pins_a(pins_a), .preset_pins_b(pins_b),
    .ddc_i_a(smp), .ddc_q_a(-smp), .ddc_i_b(smp), .ddc_q_b(-smp),
    .conv_data_a(conv_a), .conv_data_b(conv_b),
    .chan_a_range_flag_zero(flags[0]), .chan_a_range_flag_one(flags[1]),
    .chan_b_range_flag_zero(flags[2]), .chan_b_range_flag_one(flags[3]),
    .link_range_bits(link), .active_preset_a(pre_a), .active_preset_b(pre_b),
    .active_freq_a(fr_a), .active_freq_b(fr_b), .active_phase_a(ph_a),
    .active_phase_b(ph_b), .dig_data_a(dig_a), .dig_data_b(dig_b), .dig_pd_a(pd_a),
    .dig_pd_b(pd_b), .serial_link_enable(link_en), .cal_enable(cal_en),
    .single_channel(single), .irq(irq));
  ddcb_ctrl_model i_ctrl (.pclk(pclk), .presetn(presetn), .want_a(want_a),
    .want_b(want_b), .range_flag(flags[0]), .preset_pins_a(pins_a),
    .preset_pins_b(pins_b), .pulse_len(plen));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 16)
    begin
      num_errors++;
      tally_and_finish();
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input string nm, input logic [9:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk(nm, rdv, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // one-cycle sample on all four paths; q paths see the negated value
  task automatic hit(input logic [15:0] v, input logic [3:0] lk, input logic [3:0] fl);
    @(posedge pclk);
    smp <= v;
    @(posedge pclk);
    smp <= 16'h0000;
    @(negedge pclk);
    chk("link", {28'h0, link}, {28'h0, lk});
    chk("flags", {28'h0, flags}, {28'h0, fl});
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    chk("freq_rst", fr_a, RST_FREQ);
    presetn <= 1'b1;
    rd("cfg", IDX_OVER_RANGE_OUTPUT_CONFIG, 32'h7);
    rd("mode", IDX_MODE, 32'h0);
    rd("sel", IDX_SEL, 32'h0);
    rd("bind", IDX_BIND, 32'h2);
    rd("bad", 10'h3FF, 32'h0);
    chk("slverr", {31'h0, errv}, 32'h1);
    chk("dig_a", {16'h0, dig_a}, {16'h0, conv_a});
    chk("dig_b", {16'h0, dig_b}, {16'h0, conv_b});
    wr(IDX_CTRL, 32'h0);
    wr(IDX_BIND, 32'h3);
    wt(1);
    chk("dig_a", {16'h0, dig_a}, {16'h0, conv_b});
    wr(IDX_BIND, 32'h0);
    wt(1);
    chk("dig_b", {16'h0, dig_b}, {16'h0, conv_a});
    wr(IDX_CTRL, 32'h1);
    wt(1);
    chk("pd", {30'h0, pd_b, pd_a}, 32'h3);
    wr(IDX_BIND, 32'h2);
    wt(1);
    chk("pd", {30'h0, pd_b, pd_a}, 32'h1);
    wr(IDX_CTRL, 32'h0);
    for (int n = 0; n < 4; n++)
    begin
      wr(IDX_FREQ_A + 10'(n), 32'hA0000000 + 32'(n));
      wr(IDX_FREQ_B + 10'(n), 32'hB0000000 + 32'(n));
      wr(IDX_PHASE_A + 10'(n), 32'h1100 + 32'(n));
      wr(IDX_PHASE_B + 10'(n), 32'h2200 + 32'(n));
    end
    for (int n = 0; n < 4; n++)
    begin
      wr(IDX_SEL, {28'h0, 2'(3 - n), 2'(n)});
      wt(1);
      chk("fa", fr_a, 32'hA0000000 + 32'(n));
      chk("fb", fr_b, 32'hB0000000 + 32'(3 - n));
      chk("pa", {16'h0, ph_a}, 32'h1100 + 32'(n));
      chk("pb", {16'h0, ph_b}, 32'h2200 + 32'(3 - n));
    end
    wr(IDX_CTRL, 32'h1C);
    wr(IDX_SEL, 32'hD);
    wt(1);
    chk("single", {30'h0, pre_b}, 32'h1);
    chk("single_f", fr_a, 32'hA0000001);
    chk("ctl", {29'h0, cal_en, link_en, single}, 32'h7);
    wr(IDX_CTRL, 32'h0);
    for (int m = 1; m < 3; m++)
    begin
      wr(IDX_MODE, 32'(m));
      for (int n = 0; n < 4; n++)
      begin
        @(posedge pclk);
        want_a <= 2'(n);
        want_b <= 2'(3 - n);
        wt(4);
        chk("pre_a", {30'h0, pre_a}, 32'(n));
        chk("pre_b", {30'h0, pre_b}, (m == 1) ? 32'(3 - n) : 32'(n));
      end
    end
    wr(IDX_MODE, 32'h3);
    wt(1);
    chk("rsvd", {28'h0, pre_b, pre_a}, 32'hD);
    hit(16'h7800, 4'hA, 4'h0);
    rd("stat", IDX_IRQ_STAT, 32'hA);
    for (int e = 0; e < 3; e++)
    begin
      wr(IDX_OVER_RANGE_OUTPUT_CONFIG, (e == 2) ? 32'hF : 32'h8 + 32'(e));
      hit(16'h7FFF, 4'hF, 4'hF);
      wt((8 << ((e == 2) ? 7 : e)) + 8);
      chk("len", {20'h0, plen}, 32'(8 << ((e == 2) ? 7 : e)));
    end
    wr(IDX_IRQ_MASK, 32'h1);
    wt(1);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(IDX_IRQ_STAT, 32'hF);
    rd("stat", IDX_IRQ_STAT, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 32'h0);
    hit(16'h7FFF, 4'hF, 4'hF);
    wt(1);
    chk("irq", {31'h0, irq}, 32'h0);
    tally_and_finish();
  end
  initial
  begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end
endmodule
